// *** src/itd_params.svh ***
// Constants for the instruction timing decoder: option word layout,
// opcodes, register offsets, reset values and cycle counts.
// Assumes it is included by bare name from files that need it.
//
// Contract
// - Decode every fetched word as 13 bits.
// - Option bit 8 picks two or four periods.
// - Program counter writes take two cycles.
// - Option bit 6 sets jump/call length.
// - Two-cycle mode: branches, returns, skips take two.
// - Counter clock follows selected instruction period.
// - Option bit 7 low enables the watchdog.
// - Option bit 4 selects crystal or RC.
// - Option bit 3 selects high or low power.
// - Protection off only when bits 2..0 all set.
// - Option word unreachable by instructions; bits 12..9 unused.
// - Words one and two hold customer ID.
// - Bit ops set, clear, test any bit.
// - I/O registers addressed like general registers.
// - Control moves reach port controls and masks only.
// - Return from interrupt also sets global enable.
// - Sleep clears watchdog, stops oscillator, updates flags.
// - Flag values for sleep, clear and timeout.
`ifndef ITD_PARAMS_SVH
`define ITD_PARAMS_SVH

// ************************************************************
// Option word fields
// ************************************************************
`define ITD_WORD_W 13
`define ITD_OPT_CLKS 8
`define ITD_OPT_WDT_DIS 7
`define ITD_OPT_BRANCH_CYCLE_SELECT 6
`define ITD_OPT_OSC 4
`define ITD_OPT_PWR 3
`define ITD_OPT_PR_HI 2
`define ITD_OPT_PR_LO 0

// ************************************************************
// Opcodes and operand values
// ************************************************************
`define ITD_OP_SLEEP 13'h0003
`define ITD_OP_WATCHDOG_CLEAR_INSTR 13'h0004
`define ITD_OP_ENI 13'h0010
`define ITD_OP_DISI 13'h0011
`define ITD_OP_RET 13'h0012
`define ITD_OP_RETURN_FROM_INTERRUPT 13'h0013
`define ITD_PC_REG 6'h02
`define ITD_CREG_PORT_LO 4'h6
`define ITD_CREG_PORT_HI 4'hA
`define ITD_CREG_MASK1 4'hE
`define ITD_CREG_MASK2 4'hF

// ************************************************************
// Timing counts in oscillator (pclk) periods
// ************************************************************
`define ITD_DIV_FAST 3'h2
`define ITD_DIV_SLOW 3'h4
`define ITD_CFG_SETTLE 2'h3

// ************************************************************
// Register offsets and reset values
// ************************************************************
`define ITD_OFF_CTRL 12'h000
`define ITD_OFF_STATUS 12'h004
`define ITD_OFF_CFG 12'h008
`define ITD_OFF_CUST_ID 12'h00C
`define ITD_OFF_LAST 12'h010
`define ITD_CTRL_RUN_RST 1'h1
`define ITD_FLAG_RST 1'h1

`endif

// *** src/itd_pkg.sv ***
// Types shared by the instruction timing decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package itd_pkg;

  // ************************************************************
  // Sequencer states, one-hot
  // ************************************************************
  typedef enum logic [3:0] {
    ITD_ST_LOAD  = 4'h1,   // Waiting for the option word to settle.
    ITD_ST_RUN   = 4'h2,   // Fetching one word per instruction cycle.
    ITD_ST_WAIT  = 4'h4,   // Second cycle of a two-cycle instruction.
    ITD_ST_SLEEP = 4'h8    // Oscillator stopped until wake.
  } itd_state_t;

  // Kinds of bit operation, in opcode order.
  typedef enum logic [1:0] {
    ITD_BIT_CLEAR     = 2'h0,
    ITD_BIT_SET       = 2'h1,
    ITD_BIT_SKIP_CLR  = 2'h2,
    ITD_BIT_SKIP_SET  = 2'h3
  } itd_bit_op_t;

endpackage : itd_pkg

// *** src/itd_cycle_gen.sv ***
// Instruction cycle generator: divides the oscillator clock by two or four.
// Assumes pclk is the oscillator clock and that run is synchronous to it.
`timescale 1ns/10ps
`include "itd_params.svh"

module itd_cycle_gen (
  input logic pclk,         // Oscillator clock.
  input logic presetn,      // Asynchronous reset, active low.
  input logic period_four,  // High selects four periods per cycle.
  input logic run,          // Low holds the divider, as a stopped oscillator.
  output logic inst_tick,   // One-pclk pulse per instruction cycle.
  output logic tcc_tick     // Counter clock enable, same rate.
);

  logic [2:0] cnt;       // Position inside the current instruction cycle.
  logic [2:0] last_pos;  // Final position for the selected period.

  // ************************************************************
  // Divider
  // ************************************************************
  // Final count follows the period bit.
  assign last_pos = period_four ? (`ITD_DIV_SLOW - 3'h1) : (`ITD_DIV_FAST - 3'h1);

  // Count oscillator periods; a stopped oscillator restarts a fresh cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
    end else if (!run || cnt >= last_pos) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  // Ticks are registered so downstream logic sees clean strobes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inst_tick <= 1'b0;
      tcc_tick <= 1'b0;
    end else begin
      inst_tick <= run && (cnt == last_pos);
      tcc_tick <= run && (cnt == last_pos);
    end
  end

endmodule : itd_cycle_gen

// *** src/itd_instr_timing_decoder.sv ***
// Instruction decode and cycle timing for an 8-bit core, with APB status.
// Assumes program memory returns instr_data in the cycle fetch_en is high,
// and that the option and ID pins hold steady from power-on.
`timescale 1ns/10ps
`include "itd_params.svh"

module itd_instr_timing_decoder (
  input logic pclk,              // Oscillator clock, 10 MHz.
  input logic presetn,           // Asynchronous reset, active low.
  input logic psel,              // APB select.
  input logic penable,           // APB access phase.
  input logic pwrite,            // APB write.
  input logic [11:0] paddr,      // APB byte address.
  input logic [31:0] pwdata,     // APB write data.
  output logic [31:0] prdata,    // APB read data.
  output logic pready,           // APB ready.
  output logic pslverr,          // APB error on unmapped address.
  input logic [12:0] opt_word_pin,  // Non-volatile option word.
  input logic [12:0] id_word1_pin,  // Customer ID word one.
  input logic [12:0] id_word2_pin,  // Customer ID word two.
  input logic wake_pin,          // Wake request, asynchronous.
  input logic wdt_timeout,       // Watchdog timeout pulse.
  input logic [12:0] instr_data, // Word from program memory.
  output logic fetch_en,         // Program memory read this cycle.
  output logic exec_stb,         // New instruction latched.
  output logic [12:0] instr_word, // Latched instruction.
  output logic [5:0] reg_addr,   // Register operand.
  output logic [2:0] bit_sel,    // Bit select of bit operations.
  output logic bit_op_stb,       // Bit operation issued.
  output logic [1:0] bit_op_kind, // Clear, set, skip if clear, skip if set.
  output logic ctrl_wr_stb,      // Accumulator to control register.
  output logic ctrl_rd_stb,      // Control register to accumulator.
  output logic [3:0] ctrl_addr,  // Control register address.
  output logic gie_set_stb,      // Set global interrupt enable.
  output logic gie_clr_stb,      // Clear global interrupt enable.
  output logic wdt_clr_stb,      // Clear watchdog counter.
  output logic sleep_stb,        // Sleep issued.
  output logic osc_stopped,      // Oscillator stopped.
  output logic tcc_tick,         // Free running counter clock enable.
  output logic timeout_flag,     // Timeout status flag.
  output logic powerdown_flag,   // Power down status flag.
  output logic cfg_period_four,  // Four periods per instruction.
  output logic cfg_branch_two,   // Two-cycle branch mode.
  output logic watchdog_enable,  // Watchdog enabled.
  output logic osc_crystal,      // Crystal oscillator selected.
  output logic power_high,       // High power selected.
  output logic code_protect,     // Code protection active.
  output logic cfg_loaded        // Option word latched.
);

  // ************************************************************
  // Decode functions
  // ************************************************************
  // A byte operation that writes its register operand back.
  function automatic logic writes_reg(input logic [12:0] w);
    writes_reg = (w[12:11] == 2'b00) && w[6];
  endfunction : writes_reg

  // Any word that changes the program counter through its register.
  function automatic logic pc_write(input logic [12:0] w);
    logic bitw;
    bitw = (w[12:10] == 3'b010) || (w[12:9] == 4'b0101);
    pc_write = (writes_reg(w) || (bitw && w[12:11] == 2'b01 && !w[10]))
               && (w[5:0] == `ITD_PC_REG);
  endfunction : pc_write

  // Conditional skips: decrement or increment-skip and bit tests.
  function automatic logic is_skip(input logic [12:0] w);
    is_skip = ((w[12:8] == 5'h05 || w[12:8] == 5'h07) && w[7])
              || (w[12:11] == 2'b01 && w[10]);
  endfunction : is_skip

  // Returns of every kind.
  function automatic logic is_return(input logic [12:0] w);
    is_return = (w == `ITD_OP_RET) || (w == `ITD_OP_RETURN_FROM_INTERRUPT) || (w[12:8] == 5'h1C);
  endfunction : is_return

  // Control register numbers that the move instructions may touch.
  function automatic logic ctrl_legal(input logic [3:0] a);
    ctrl_legal = (a >= `ITD_CREG_PORT_LO && a <= `ITD_CREG_PORT_HI)
                 || a == `ITD_CREG_MASK1 || a == `ITD_CREG_MASK2;
  endfunction : ctrl_legal

  // ************************************************************
  // Pin synchronisers and option capture
  // ************************************************************
  logic [38:0] nv_meta;   // First stage of the non-volatile pin sync.
  logic [38:0] nv_sync;   // Second stage, safe to read.
  logic [1:0] wake_meta;  // Wake pin sync, stage one then two.
  logic [1:0] settle;     // Cycles since reset release.
  logic [12:0] opt_word;  // Latched option word.
  logic [12:0] id_word1;  // Latched customer ID word one.
  logic [12:0] id_word2;  // Latched customer ID word two.

  // Two flip-flops before anything reads the pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_meta <= 39'h0;
      nv_sync <= 39'h0;
      wake_meta <= 2'h0;
    end else begin
      nv_meta <= {id_word2_pin, id_word1_pin, opt_word_pin};
      nv_sync <= nv_meta;
      wake_meta <= {wake_meta[0], wake_pin};
    end
  end

  // Capture once the synchroniser is full, then hold until the next reset.
  // No instruction path reaches these words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle <= 2'h0;
      cfg_loaded <= 1'b0;
      opt_word <= 13'h0000;
      id_word1 <= 13'h0000;
      id_word2 <= 13'h0000;
    end else if (!cfg_loaded) begin
      if (settle == `ITD_CFG_SETTLE) begin
        cfg_loaded <= 1'b1;
        opt_word <= nv_sync[12:0];
        id_word1 <= nv_sync[25:13];
        id_word2 <= nv_sync[38:26];
      end else begin
        settle <= settle + 2'h1;
      end
    end
  end

  // Option fields; bits 12 to 9 and 5 are left unused.
  assign cfg_period_four = opt_word[`ITD_OPT_CLKS];
  assign watchdog_enable = !opt_word[`ITD_OPT_WDT_DIS];
  assign cfg_branch_two = opt_word[`ITD_OPT_BRANCH_CYCLE_SELECT];
  assign osc_crystal = opt_word[`ITD_OPT_OSC];
  assign power_high = opt_word[`ITD_OPT_PWR];
  assign code_protect = !(&opt_word[`ITD_OPT_PR_HI:`ITD_OPT_PR_LO]);

  // ************************************************************
  // Instruction cycle timing
  // ************************************************************
  itd_pkg::itd_state_t state;  // Sequencer state.
  logic inst_tick;             // Instruction cycle strobe.
  logic run_en;                // Software run enable.
  logic illegal_ctrl;          // Sticky illegal control access.
  logic two_cycle;             // Fetched word needs a second cycle.

  itd_cycle_gen u_cycle_gen (
    .pclk(pclk),
    .presetn(presetn),
    .period_four(cfg_period_four),
    .run(state != itd_pkg::ITD_ST_SLEEP && state != itd_pkg::ITD_ST_LOAD),
    .inst_tick(inst_tick),
    .tcc_tick(tcc_tick)
  );

  // Memory is read only at a cycle boundary while running.
  assign fetch_en = inst_tick && run_en && (state == itd_pkg::ITD_ST_RUN);

  // Cycle count of the word now arriving.
  assign two_cycle = pc_write(instr_data)
                     || (cfg_branch_two && (instr_data[12:11] == 2'b10
                         || is_return(instr_data) || is_skip(instr_data)));

  // Sequencer: one word per cycle, a hold cycle for long ones, sleep to wake.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= itd_pkg::ITD_ST_LOAD;
    end else begin
      case (state)
        itd_pkg::ITD_ST_LOAD: begin
          if (cfg_loaded) begin
            state <= itd_pkg::ITD_ST_RUN;
          end
        end
        itd_pkg::ITD_ST_RUN: begin
          if (fetch_en && instr_data == `ITD_OP_SLEEP) begin
            state <= itd_pkg::ITD_ST_SLEEP;
          end else if (fetch_en && two_cycle) begin
            state <= itd_pkg::ITD_ST_WAIT;
          end
        end
        itd_pkg::ITD_ST_WAIT: begin
          if (inst_tick) begin
            state <= itd_pkg::ITD_ST_RUN;
          end
        end
        itd_pkg::ITD_ST_SLEEP: begin
          if (wake_meta[1]) begin
            state <= itd_pkg::ITD_ST_RUN;
          end
        end
        default: begin
          state <= itd_pkg::ITD_ST_LOAD;
        end
      endcase
    end
  end

  // Oscillator stop follows the sleep state, registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_stopped <= 1'b0;
    end else begin
      osc_stopped <= (state == itd_pkg::ITD_ST_SLEEP) && !wake_meta[1];
    end
  end

  // ************************************************************
  // Decode and strobes
  // ************************************************************
  // The 13-bit word splits into opcode and operand fields; register
  // operands cover I/O and general registers alike.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_stb <= 1'b0;
      instr_word <= 13'h0000;
      reg_addr <= 6'h00;
      bit_sel <= 3'h0;
      bit_op_kind <= 2'h0;
      ctrl_addr <= 4'h0;
    end else begin
      exec_stb <= fetch_en;
      if (fetch_en) begin
        instr_word <= instr_data;
        reg_addr <= instr_data[5:0];
        bit_sel <= instr_data[8:6];
        bit_op_kind <= instr_data[10:9];
        ctrl_addr <= instr_data[3:0];
      end
    end
  end

  // One-pclk command strobes for the rest of the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_op_stb <= 1'b0;
      ctrl_wr_stb <= 1'b0;
      ctrl_rd_stb <= 1'b0;
      gie_set_stb <= 1'b0;
      gie_clr_stb <= 1'b0;
      wdt_clr_stb <= 1'b0;
      sleep_stb <= 1'b0;
    end else begin
      bit_op_stb <= fetch_en && (instr_data[12:11] == 2'b01);
      // Only port controls and mask registers pass.
      ctrl_wr_stb <= fetch_en && instr_data[12:4] == 9'h000
                     && ctrl_legal(instr_data[3:0]);
      ctrl_rd_stb <= fetch_en && instr_data[12:4] == 9'h001
                     && ctrl_legal(instr_data[3:0]);
      // Return from interrupt also re-enables interrupts.
      gie_set_stb <= fetch_en && (instr_data == `ITD_OP_RETURN_FROM_INTERRUPT || instr_data == `ITD_OP_ENI);
      gie_clr_stb <= fetch_en && instr_data == `ITD_OP_DISI;
      // Both sleep and watchdog clear zero the watchdog.
      wdt_clr_stb <= fetch_en && (instr_data == `ITD_OP_SLEEP || instr_data == `ITD_OP_WATCHDOG_CLEAR_INSTR);
      sleep_stb <= fetch_en && instr_data == `ITD_OP_SLEEP;
    end
  end

  // Status flags; an instruction in the same cycle as a timeout wins,
  // because it reflects the newer state of the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= `ITD_FLAG_RST;
      powerdown_flag <= `ITD_FLAG_RST;
    end else if (fetch_en && instr_data == `ITD_OP_SLEEP) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (fetch_en && instr_data == `ITD_OP_WATCHDOG_CLEAR_INSTR) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (wdt_timeout) begin
      timeout_flag <= 1'b0;
    end
  end

  // ************************************************************
  // APB register file
  // ************************************************************
  logic acc_wr;  // Write takes effect this edge.
  logic hit;     // Address maps to a register.
  assign pready = 1'b1;
  assign acc_wr = psel && penable && pwrite;
  assign hit = paddr == `ITD_OFF_CTRL || paddr == `ITD_OFF_STATUS || paddr == `ITD_OFF_CFG
               || paddr == `ITD_OFF_CUST_ID || paddr == `ITD_OFF_LAST;

  // Control: bit 0 runs the fetch; a 1 on bit 1 clears the sticky flag.
  // A new illegal access in the clearing cycle keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en <= `ITD_CTRL_RUN_RST;
      illegal_ctrl <= 1'b0;
    end else begin
      if (acc_wr && paddr == `ITD_OFF_CTRL) begin
        run_en <= pwdata[0];
      end
      if (fetch_en && instr_data[12:5] == 8'h00 && instr_data[3:0] > 4'h4
          && !ctrl_legal(instr_data[3:0])) begin
        illegal_ctrl <= 1'b1;
      end else if (acc_wr && paddr == `ITD_OFF_CTRL && pwdata[1]) begin
        illegal_ctrl <= 1'b0;
      end
    end
  end

  // Read data is formed in the setup phase, so no wait states are needed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !hit;
      if (pwrite || !hit) begin
        prdata <= 32'h0000_0000;
      end else if (paddr == `ITD_OFF_CTRL) begin
        prdata <= {31'h0, run_en};
      end else if (paddr == `ITD_OFF_STATUS) begin
        prdata <= {24'h0, state, illegal_ctrl, cfg_loaded, powerdown_flag, timeout_flag};
      end else if (paddr == `ITD_OFF_CFG) begin
        prdata <= {26'h0, code_protect, power_high, osc_crystal, cfg_branch_two,
                   watchdog_enable, cfg_period_four};
      end else if (paddr == `ITD_OFF_CUST_ID) begin
        prdata <= {3'h0, id_word2, 3'h0, id_word1};
      end else begin
        prdata <= {19'h0, instr_word};
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PERIOD_FOUR: assert property (
    inst_tick && cfg_period_four && state == itd_pkg::ITD_ST_WAIT
    |=> !inst_tick [*3])
    else $error("Slow instruction cycle shorter than four periods.");

  AST_PERIOD_TWO: assert property (
    tcc_tick && !cfg_period_four && state == itd_pkg::ITD_ST_WAIT |=> !tcc_tick ##1 tcc_tick)
    else $error("Fast counter clock not every two periods.");

  AST_PC_WRITE_TWO: assert property (
    fetch_en && pc_write(instr_data) && instr_data != `ITD_OP_SLEEP
    |=> state == itd_pkg::ITD_ST_WAIT)
    else $error("Program counter write did not take two cycles.");

  AST_BRANCH_ONE: assert property (
    fetch_en && !cfg_branch_two && instr_data[12:11] == 2'b10
    |=> state == itd_pkg::ITD_ST_RUN)
    else $error("Jump took two cycles in one-cycle mode.");

  AST_BRANCH_TWO: assert property (
    fetch_en && cfg_branch_two && (is_skip(instr_data) || is_return(instr_data))
    |=> state == itd_pkg::ITD_ST_WAIT ##1 !fetch_en)
    else $error("Skip or return took one cycle in two-cycle mode.");

  AST_PROTECT: assert property (
    cfg_loaded |-> code_protect == (opt_word[2:0] != 3'h7))
    else $error("Code protection decode wrong.");

  AST_CFG_HELD: assert property (
    cfg_loaded && $past(cfg_loaded) |-> $stable(opt_word) && $stable(id_word1))
    else $error("Option word changed while running.");

  AST_CTRL_LEGAL: assert property (
    ctrl_wr_stb || ctrl_rd_stb |-> ctrl_legal(ctrl_addr) && $past(fetch_en))
    else $error("Control move reached an illegal register.");

  AST_RETURN_FROM_INTERRUPT_GIE: assert property (
    fetch_en && instr_data == `ITD_OP_RETURN_FROM_INTERRUPT |=> gie_set_stb && exec_stb)
    else $error("Return from interrupt did not set global enable.");

  AST_SLEEP_FLAGS: assert property (
    sleep_stb |-> wdt_clr_stb && timeout_flag && !powerdown_flag ##1 osc_stopped)
    else $error("Sleep did not clear watchdog, stop oscillator and set flags.");

  AST_TIMEOUT_FLAG: assert property (
    wdt_timeout && !fetch_en |=> !timeout_flag && $stable(powerdown_flag))
    else $error("Watchdog timeout flag update wrong.");

  AST_WATCHDOG_CLEAR_INSTR_FLAGS: assert property (
    fetch_en && instr_data == `ITD_OP_WATCHDOG_CLEAR_INSTR |=> timeout_flag && powerdown_flag && wdt_clr_stb)
    else $error("Watchdog clear did not set both flags.");

endmodule : itd_instr_timing_decoder

// *** testbench/itd_prog_mem.sv ***
// Program memory model that feeds the decoder one word per fetch.
// Assumes the bench fills mem before reset is released.
`timescale 1ns/10ps
module itd_prog_mem (
  input logic pclk, // Oscillator clock.
  input logic presetn, // Reset, active low; restarts the program at word zero.
  input logic fetch_en, // Fetch request from the decoder.
  output logic [12:0] instr_data // Program word.
);
  logic [12:0] mem [0:15]; // Program, filled by the bench.
  logic [3:0] pc; // Index of the next word.
  // Valid only in the fetch cycle; otherwise it toggles so stale data cannot pass.
  always_comb instr_data = fetch_en ? mem[pc] : {13{pclk}};
  // Step on every taken fetch; the order is linear, which is all the decoder needs.
  // A reset restarts the program, so a second run can reuse the memory.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pc <= 4'h0;
    else if (fetch_en) pc <= pc + 4'h1;
  end
endmodule : itd_prog_mem

// *** testbench/tb_top.sv ***
// Self-checking bench for the instruction timing decoder.
// Assumes the memory model in itd_prog_mem.sv and zero-wait APB.
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [27:0] v; logic [27:0] m; int g;} itd_exp_t; // Expected decode.
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wake_pin = 1'b0, wdt_timeout = 1'b0, pready, pslverr, fetch_en, exec_stb;
  logic bit_op_stb, ctrl_wr_stb, ctrl_rd_stb, gie_set_stb, wdt_clr_stb, sleep_stb;
  logic osc_stopped, timeout_flag, powerdown_flag;
  logic [11:0] paddr = 12'h000; // Bus address.
  logic [31:0] pwdata = 32'h0, prdata; // Bus data.
  logic [12:0] opt_word_pin = 13'h0058, id_word1_pin = 13'h0, id_word2_pin = 13'h0;
  logic [12:0] instr_data, instr_word;
  logic [2:0] bit_sel; logic [1:0] bit_op_kind; logic [3:0] ctrl_addr;
  itd_exp_t exp_q[$], e; // Notes from the driver, oldest first.
  int miscompares = 0, comparisons = 0, n = 0, last = 0, gap = 0;
  always #50 pclk = ~pclk;
  itd_instr_timing_decoder itd_instr_timing_decoder_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .opt_word_pin, .id_word1_pin,
    .id_word2_pin, .wake_pin, .wdt_timeout, .instr_data, .fetch_en, .exec_stb, .instr_word,
    .reg_addr(), .bit_sel, .bit_op_stb, .bit_op_kind, .ctrl_wr_stb, .ctrl_rd_stb, .ctrl_addr,
    .gie_set_stb, .gie_clr_stb(), .wdt_clr_stb, .sleep_stb, .osc_stopped, .tcc_tick(),
    .timeout_flag, .powerdown_flag, .cfg_period_four(), .cfg_branch_two(),
    .watchdog_enable(), .osc_crystal(), .power_high(), .code_protect(), .cfg_loaded());
  itd_prog_mem itd_prog_mem_i (.pclk, .presetn, .fetch_en, .instr_data);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] x, y);
    comparisons++;
    if (x !== y) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, x, y);
    end
  endtask : chk
  // Stores a word and notes its decode; the gap is the previous word's length.
  task automatic put(input logic [12:0] w, input logic [5:0] s, input logic [8:0] f, fm,
      input int len);
    exp_q.push_back('{{w, s, f}, {13'h1FFF, 6'h3F, fm}, last});
    itd_prog_mem_i.mem[n] = w;
    n++;
    last = len;
  endtask : put
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic er);
    int t;
    t = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && t++ < 50);
    if (pready !== 1'b1) miscompares++;
    r = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Waits until k notes are left; running out of time counts as a mismatch.
  task automatic drain(input int k);
    int t;
    t = 0;
    while (exp_q.size() > k && t++ < 2000) @(posedge pclk);
    chk("notes_left", k, exp_q.size());
  endtask : drain
  task automatic final_report;
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // Monitor: each new instruction takes the oldest note; its spacing is checked unless the note's gap is zero.
  always @(posedge pclk) begin
    gap <= exec_stb ? 1 : gap + 1;
    if (exec_stb && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("decode", e.v & e.m, {instr_word, bit_op_stb, ctrl_wr_stb, ctrl_rd_stb, gie_set_stb,
        wdt_clr_stb, sleep_stb, bit_sel, bit_op_kind, ctrl_addr} & e.m);
      if (e.g != 0) chk("cycles", e.g, gap);
    end
  end
  // Watchdog: the whole run needs well under a thousand cycles.
  initial begin
    #3000000;
    miscompares++;
    final_report();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [2:0] b; logic [5:0] r; logic [31:0] rd; logic er;
    void'($urandom(14));
    opt_word_pin <= {4'($urandom), 9'h058}; // Unused high bits are random.
    id_word1_pin <= 13'($urandom);
    id_word2_pin <= 13'($urandom);
    put(13'h0000, 6'h00, 9'h0, 9'h0, 2);
    for (int k = 0; k < 4; k++) begin
      b = 3'($urandom);
      r = 6'(3 + $urandom % 61);
      put({2'b01, 2'(k), b, r}, 6'h20, {b, 2'(k), 4'h0}, 9'h1F0, k > 1 ? 4 : 2);
    end
    put({4'b0101, b, 6'h02}, 6'h20, 9'h0, 9'h0, 4);
    put(13'h0042, 6'h00, 9'h0, 9'h0, 4);
    put(13'h1400 | 13'($urandom % 1024), 6'h00, 9'h0, 9'h0, 4);
    put(13'h0006, 6'h10, 9'h006, 9'h00F, 2);
    put(13'h001F, 6'h08, 9'h00F, 9'h00F, 2);
    put(13'h0005, 6'h00, 9'h0, 9'h0, 2);
    put(13'h000E, 6'h10, 9'h00E, 9'h00F, 2);
    put(13'h0013, 6'h04, 9'h0, 9'h0, 4);
    put(13'h0004, 6'h02, 9'h0, 9'h0, 2);
    put(13'h0003, 6'h03, 9'h0, 9'h0, 0);
    put(13'h0004, 6'h02, 9'h0, 9'h0, 2);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk); // The option word is latched four edges after release.
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk("cfg", 32'h3E, rd);
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    chk("cust_id", {3'h0, id_word2_pin, 3'h0, id_word1_pin}, rd);
    apb(1'b1, 12'h000, 32'h1, rd, er);
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, 12'h020, 32'h0, rd, er);
    chk("unmapped", 32'h1, {rd[30:0], er});
    drain(1);
    repeat (3) @(posedge pclk);
    chk("sleep", 3'b110, {osc_stopped, timeout_flag, powerdown_flag});
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk("status", 32'h8D, rd);
    wdt_timeout <= 1'b1;
    @(posedge pclk) wdt_timeout <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("timeout", 3'b100, {osc_stopped, timeout_flag, powerdown_flag});
    wake_pin <= 1'b1;
    drain(0);
    wake_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("wake", 3'b011, {osc_stopped, timeout_flag, powerdown_flag});
    // Second run: four-period cycle, one-cycle branches, protection off.
    presetn <= 1'b0;
    opt_word_pin <= 13'h0187;
    @(posedge pclk);
    n = 0;
    last = 0;
    put(13'h0000, 6'h00, 9'h0, 9'h0, 4);
    put(13'h1400 | 13'($urandom % 1024), 6'h00, 9'h0, 9'h0, 4);
    put(13'h0042, 6'h00, 9'h0, 9'h0, 8);
    put(13'h0004, 6'h02, 9'h0, 9'h0, 4);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk("cfg_slow", 32'h01, rd);
    drain(0);
    final_report();
  end
endmodule : tb_top
